// file: hdl/mmsl_consts.svh
// Constants of the module-select, management link and indicator block.
`ifndef MMSL_CONSTS_SVH
`define MMSL_CONSTS_SVH
`define MMSL_DEV_ADDR 7'h50
`define MMSL_ID_ADDR 8'h80
`define MMSL_ID_VALUE 8'h0D
`define MMSL_PAGE_BITS 7
`define MMSL_CORE_CLK_NS 50
`define MMSL_LINK_CLK_NS 12
`define MMSL_STRETCH_MAX_NS 500000
`define MMSL_STRETCH_LOAD_CYC 4'h3
`define MMSL_BLINK_NS 1000000000
`endif

// file: hdl/mmsl_pkg.sv
// Types of the module-select, management link and indicator block.
package mmsl_pkg;
   typedef enum logic [2:0] {
      LS_IDLE, LS_ADDR, LS_ADDR_ACK, LS_WDATA, LS_WACK, LS_RDATA,
      LS_RACK, LS_RNEXT
   } mmsl_link_state_e;
   typedef logic [7:0] mmsl_byte_t;
endpackage

// file: hdl/mmsl_top.sv
// Two-wire management slave with module select and two-colour indicator.
//
// Behaviour
// [RL1] Answer only device address 1010000, ignore others.
// [RL2] Deselected module never acknowledges nor acts.
// [RL3] Select input defaults to deselected.
// [RL4] Host selects one module, deselects all others.
// [RL5] Host selects at least 2 ms before start.
// [RL6] Host holds select 10 us past stop.
// [RL7] Clock stretching releases within 500 us.
// [RL8] Steady green in high-power mode.
// [RL9] Steady red in low-power mode without alarm.
// [RL10] Alarm blinks green and red, overriding colours.
// [RL11] Byte 128 of upper page zero identifies map.
// [RL12] Address LSB selects read or write.
// [RL13] Module acknowledges addresses and written bytes.
// [RL14] Address counter advances, wraps within page.
// [RL15] Bytes are eight bits, MSB first.
// [RL16] Blink period fixed, about one toggle per second.
// [RL17] Indicator derived from inputs, registered output.
`timescale 1ns/1ps
`include "mmsl_consts.svh"

module mmsl_top
   import mmsl_pkg::*;
#(
   parameter int STRETCH_MAX = `MMSL_STRETCH_MAX_NS / `MMSL_LINK_CLK_NS,
   parameter int BLINK_CYC = `MMSL_BLINK_NS / `MMSL_CORE_CLK_NS
) (
   input wire logic core_clk,
   input wire logic reset,
   input wire logic link_clk,
   input wire logic module_select_n,
   input wire logic scl_i,
   output logic scl_o,
   output logic scl_oe,
   input wire logic sda_i,
   output logic sda_o,
   output logic sda_oe,
   input wire logic power_high,
   input wire logic temp_alarm,
   output logic led_green,
   output logic led_red,
   output logic mgmt_busy
);

   logic sel_n_m, sel_n_s, scl_m, scl_s, scl_d, sda_m, sda_s, sda_d;
   logic scl_rise, scl_fall, start_c, stop_c;
   mmsl_link_state_e st_r;
   logic [3:0] cnt_r;
   mmsl_byte_t sh_r, tx_r, addr_r, rd_byte;
   logic first_r, sda_oe_r, scl_oe_r, load_go, incr_go;
   logic [3:0] str_cnt_r;
   logic [31:0] hold_cnt_r;
   mmsl_byte_t mem_r [0:255];
   logic busy_r, busy_m, busy_s, mgmt_busy_r;
   logic [31:0] blink_cnt_r;
   logic phase_r, led_green_r, led_red_r, scl_out_r, sda_out_r;

   // Pin synchronisers; select resets high so a floating line deselects.
   always_ff @(posedge link_clk or posedge reset) begin
      if (reset) begin
         sel_n_m <= 1'b1; // [RL3]
         sel_n_s <= 1'b1;
         scl_m <= 1'b1;
         scl_s <= 1'b1;
         scl_d <= 1'b1;
         sda_m <= 1'b1;
         sda_s <= 1'b1;
         sda_d <= 1'b1;
      end else begin
         sel_n_m <= module_select_n;
         sel_n_s <= sel_n_m;
         scl_m <= scl_i;
         scl_s <= scl_m;
         scl_d <= scl_s;
         sda_m <= sda_i;
         sda_s <= sda_m;
         sda_d <= sda_s;
      end
   end

   // Bus events seen on the synchronised lines.
   assign scl_rise = scl_s & ~scl_d;
   assign scl_fall = ~scl_s & scl_d;
   assign start_c = scl_s & scl_d & sda_d & ~sda_s;
   assign stop_c = scl_s & scl_d & ~sda_d & sda_s;

   // Read byte: the map identifier is fixed, the rest comes from memory.
   assign rd_byte = (addr_r == `MMSL_ID_ADDR) ? `MMSL_ID_VALUE :
                    mem_r[addr_r]; // [RL11]
   assign load_go = scl_fall &&
                    ((st_r == LS_ADDR_ACK && sh_r[0]) || st_r == LS_RNEXT);
   assign incr_go = scl_fall && cnt_r == 4'h8 &&
                    (st_r == LS_RDATA || (st_r == LS_WDATA && !first_r));

   // Slave sequencer: receives on rising edges, drives on falling edges.
   always_ff @(posedge link_clk or posedge reset) begin
      if (reset) begin
         st_r <= LS_IDLE;
         cnt_r <= 4'h0;
         sh_r <= 8'h00;
         tx_r <= 8'h00;
         first_r <= 1'b0;
         sda_oe_r <= 1'b0;
      end else if (sel_n_s) begin
         st_r <= LS_IDLE; // [RL2]
         sda_oe_r <= 1'b0;
      end else if (start_c) begin
         st_r <= LS_ADDR;
         cnt_r <= 4'h0;
         first_r <= 1'b1;
         sda_oe_r <= 1'b0;
      end else if (stop_c) begin
         st_r <= LS_IDLE;
         sda_oe_r <= 1'b0;
      end else begin
         case (st_r)
            LS_ADDR, LS_WDATA: begin
               if (scl_rise) begin
                  sh_r <= {sh_r[6:0], sda_s}; // [RL15]
                  cnt_r <= cnt_r + 4'h1;
               end else if (scl_fall && cnt_r == 4'h8) begin
                  cnt_r <= 4'h0;
                  if (st_r == LS_WDATA) begin
                     st_r <= LS_WACK;
                     sda_oe_r <= 1'b1; // [RL13]
                  end else if (sh_r[7:1] == `MMSL_DEV_ADDR) begin // [RL1]
                     st_r <= LS_ADDR_ACK;
                     sda_oe_r <= 1'b1; // [RL13]
                  end else begin
                     st_r <= LS_IDLE;
                  end
               end
            end
            LS_ADDR_ACK, LS_RNEXT: begin
               if (scl_fall) begin
                  cnt_r <= 4'h0;
                  if (load_go) begin
                     st_r <= LS_RDATA; // [RL12]
                     tx_r <= rd_byte;
                     sda_oe_r <= ~rd_byte[7];
                  end else begin
                     st_r <= LS_WDATA; // [RL12]
                     sda_oe_r <= 1'b0;
                  end
               end
            end
            LS_WACK: begin
               if (scl_fall) begin
                  st_r <= LS_WDATA;
                  first_r <= 1'b0;
                  sda_oe_r <= 1'b0;
               end
            end
            LS_RDATA: begin
               if (scl_rise) begin
                  cnt_r <= cnt_r + 4'h1;
               end else if (scl_fall) begin
                  if (cnt_r == 4'h8) begin
                     st_r <= LS_RACK;
                     sda_oe_r <= 1'b0;
                  end else begin
                     tx_r <= {tx_r[6:0], 1'b0}; // [RL15]
                     sda_oe_r <= ~tx_r[6];
                  end
               end
            end
            LS_RACK: begin
               if (scl_rise) begin
                  st_r <= sda_s ? LS_IDLE : LS_RNEXT; // [RL13]
               end
            end
            default: begin
               st_r <= LS_IDLE;
            end
         endcase
      end
   end

   // Byte address counter: first written byte loads it, transfers advance.
   always_ff @(posedge link_clk or posedge reset) begin
      if (reset) begin
         addr_r <= 8'h00;
      end else if (!sel_n_s && st_r == LS_WDATA && first_r && scl_fall &&
                   cnt_r == 4'h8) begin
         addr_r <= sh_r;
      end else if (!sel_n_s && incr_go) begin
         addr_r <= {addr_r[7], addr_r[6:0] + 7'h01}; // [RL14]
      end
   end

   // Memory write; the identifier byte stays read-only.
   always_ff @(posedge link_clk) begin
      if (!sel_n_s && st_r == LS_WDATA && !first_r && scl_fall &&
          cnt_r == 4'h8 && addr_r != `MMSL_ID_ADDR) begin
         mem_r[addr_r] <= sh_r;
      end
   end

   // Short stretch while a read byte is fetched, cut by the hold limit.
   always_ff @(posedge link_clk or posedge reset) begin
      if (reset) begin
         str_cnt_r <= 4'h0;
         hold_cnt_r <= 32'h0;
         scl_oe_r <= 1'b0;
      end else begin
         if (load_go && !sel_n_s) begin
            str_cnt_r <= `MMSL_STRETCH_LOAD_CYC;
         end else if (str_cnt_r != 4'h0) begin
            str_cnt_r <= str_cnt_r - 4'h1;
         end
         hold_cnt_r <= scl_oe_r ? hold_cnt_r + 32'h1 : 32'h0;
         scl_oe_r <= (str_cnt_r != 4'h0) &&
                     (hold_cnt_r < 32'(STRETCH_MAX - 2)); // [RL7]
      end
   end

   // Link activity level and fixed-low data values of the open-drain pins.
   always_ff @(posedge link_clk or posedge reset) begin
      if (reset) begin
         busy_r <= 1'b0;
         scl_out_r <= 1'b0;
         sda_out_r <= 1'b0;
      end else begin
         busy_r <= (st_r != LS_IDLE);
         scl_out_r <= 1'b0;
         sda_out_r <= 1'b0;
      end
   end

   // Activity level crosses to the core clock through three flip-flops.
   always_ff @(posedge core_clk or posedge reset) begin
      if (reset) begin
         busy_m <= 1'b0;
         busy_s <= 1'b0;
         mgmt_busy_r <= 1'b0;
      end else begin
         busy_m <= busy_r;
         busy_s <= busy_m;
         mgmt_busy_r <= busy_s;
      end
   end

   // Blink timebase, one phase change per period.
   always_ff @(posedge core_clk or posedge reset) begin
      if (reset) begin
         blink_cnt_r <= 32'h0;
         phase_r <= 1'b0;
      end else if (blink_cnt_r == 32'(BLINK_CYC - 1)) begin
         blink_cnt_r <= 32'h0;
         phase_r <= ~phase_r; // [RL16]
      end else begin
         blink_cnt_r <= blink_cnt_r + 32'h1;
      end
   end

   // Indicator colours from power mode and alarm, registered.
   always_ff @(posedge core_clk or posedge reset) begin
      if (reset) begin
         led_green_r <= 1'b0;
         led_red_r <= 1'b0;
      end else if (temp_alarm) begin
         led_green_r <= phase_r; // [RL10] [RL17]
         led_red_r <= ~phase_r;
      end else begin
         led_green_r <= power_high; // [RL8] [RL17]
         led_red_r <= ~power_high; // [RL9]
      end
   end

   assign scl_o = scl_out_r;
   assign scl_oe = scl_oe_r;
   assign sda_o = sda_out_r;
   assign sda_oe = sda_oe_r;
   assign led_green = led_green_r;
   assign led_red = led_red_r;
   assign mgmt_busy = mgmt_busy_r;

   // Checks on the link side.
   chk_addr_reject: assert property (@(posedge link_clk) // [RL1]
      disable iff (reset) (st_r == LS_ADDR && scl_fall && cnt_r == 4'h8 &&
      sh_r[7:1] != `MMSL_DEV_ADDR) |=> !sda_oe_r ##1 !sda_oe_r)
      else $error("foreign device address acknowledged");
   chk_desel_quiet: assert property (@(posedge link_clk) // [RL2]
      disable iff (reset) sel_n_s |=> !sda_oe_r && st_r == LS_IDLE)
      else $error("deselected module is active on the bus");
   chk_default_desel: assert property (@(posedge link_clk) // [RL3]
      disable iff (reset) (sel_n_s && $past(sel_n_s) && $past(sel_n_s, 2))
      |-> !busy_r) else $error("link busy while select stays high");
   chk_stretch_bound: assert property (@(posedge link_clk) // [RL7]
      disable iff (reset) scl_oe_r |-> hold_cnt_r < STRETCH_MAX)
      else $error("clock held low too long");
   chk_id_byte: assert property (@(posedge link_clk) // [RL11]
      disable iff (reset) (load_go && !sel_n_s && addr_r == `MMSL_ID_ADDR)
      |=> tx_r == `MMSL_ID_VALUE) else $error("map identifier byte wrong");
   chk_ack_drive: assert property (@(posedge link_clk) // [RL13]
      disable iff (reset) (st_r == LS_ADDR_ACK || st_r == LS_WACK)
      |-> sda_oe_r) else $error("acknowledge bit not driven low");
   chk_page_wrap: assert property (@(posedge link_clk) // [RL14]
      disable iff (reset) (incr_go && !sel_n_s && !start_c && !stop_c) |=>
      addr_r == {$past(addr_r[7]), $past(addr_r[6:0]) + 7'h01})
      else $error("address counter did not advance within page");
   chk_read_dir: assert property (@(posedge link_clk) // [RL12]
      disable iff (reset) (st_r == LS_ADDR_ACK && scl_fall && !sel_n_s &&
      !start_c && !stop_c) |=> (st_r == LS_RDATA) == $past(sh_r[0]))
      else $error("direction bit not honoured");
   chk_msb_first: assert property (@(posedge link_clk) // [RL15]
      disable iff (reset) (st_r == LS_RDATA && scl_rise && cnt_r == 4'h0)
      |-> sda_oe_r == ~tx_r[7])
      else $error("read byte not sent msb first");

   // Checks on the indicator.
   chk_led_green: assert property (@(posedge core_clk) // [RL8]
      disable iff (reset) (power_high && !temp_alarm) |=> led_green_r &&
      !led_red_r) else $error("green not steady in high-power mode");
   chk_led_red: assert property (@(posedge core_clk) // [RL9]
      disable iff (reset) (!power_high && !temp_alarm) |=> !led_green_r &&
      led_red_r) else $error("red not steady in low-power mode");
   chk_led_blink: assert property (@(posedge core_clk) // [RL10]
      disable iff (reset) temp_alarm |=> led_green_r != led_red_r &&
      led_green_r == $past(phase_r))
      else $error("alarm does not blink");
   chk_blink_rate: assert property (@(posedge core_clk) // [RL16]
      disable iff (reset) $changed(phase_r) |-> $past(blink_cnt_r) ==
      32'(BLINK_CYC - 1)) else $error("blink phase changed off period");

endmodule

// file: verification/mmsl_host_model.sv
// Host bus master model that drives the two-wire management link.
`timescale 1ns/1ps
module mmsl_host_model
   import mmsl_pkg::*;
#(
   parameter int Q = 8
) (
   input wire logic link_clk,
   input wire logic scl_w,
   input wire logic sda_w,
   output logic scl_h,
   output logic sda_h,
   output int rd_cnt,
   output mmsl_byte_t rd_data
);
   // Both lines start released, so the pull-ups hold them high.
   initial begin
      scl_h = 1'b1;
      sda_h = 1'b1;
      rd_cnt = 0;
      rd_data = 8'h00;
   end
   // Waits a number of link clock edges.
   task automatic tick(input int n);
      repeat (n) @(posedge link_clk);
   endtask
   // Releases the clock and waits, bounded, while the module stretches it.
   task automatic clk_high();
      int w;
      w = 0;
      scl_h <= 1'b1;
      tick(1);
      while (scl_w !== 1'b1 && w < 1000) begin
         tick(1);
         w++;
      end
      tick(Q);
   endtask
   // Start condition, which also serves as a repeated start.
   task automatic start();
      sda_h <= 1'b1;
      tick(Q);
      clk_high();
      sda_h <= 1'b0;
      tick(Q);
      scl_h <= 1'b0;
      tick(Q);
   endtask
   // Stop condition, after which the bus is left free.
   task automatic stop();
      sda_h <= 1'b0;
      tick(Q);
      clk_high();
      sda_h <= 1'b1;
      tick(Q);
   endtask
   // Drives one bit in the low phase and samples the wire while high.
   task automatic bit_io(input logic b, output logic s);
      sda_h <= b;
      tick(Q);
      clk_high();
      s = sda_w;
      scl_h <= 1'b0;
      tick(Q);
   endtask
   // Sends a byte and returns whether the module acknowledged it.
   task automatic wr_byte(input mmsl_byte_t b, output logic ack);
      logic s;
      for (int i = 7; i >= 0; i--) begin
         bit_io(b[i], s);
      end
      bit_io(1'b1, s);
      ack = !s;
   endtask
   // Reads a byte; the last one is answered with no acknowledge.
   task automatic rd_byte(input logic last);
      logic s;
      mmsl_byte_t v;
      for (int i = 7; i >= 0; i--) begin
         bit_io(1'b1, s);
         v[i] = s;
      end
      bit_io(last, s);
      rd_data = v;
      rd_cnt++;
   endtask
endmodule

// file: verification/mmsl_top_test.sv
// Self-checking testbench of the management link and indicator block.
`timescale 1ns/1ps
module mmsl_top_test
   import mmsl_pkg::*;
;
   localparam int BLINK = 16;
   localparam int STRETCH = 64;
   logic core_clk, link_clk, reset, sel_en, power_high, temp_alarm, ack;
   logic scl_o, scl_oe, sda_o, sda_oe, led_green, led_red, last;
   logic scl_h, sda_h, scl_w, sda_w, module_select_n, mgmt_busy;
   logic [31:0] r;
   int n_fail, n_tests, cyc, seed, rd_cnt, run, max_run, oe_rises, flips;
   mmsl_byte_t rd_data, d0, d1;
   mmsl_byte_t exp_q[$];
   // Open-drain wires with pull-ups; an undriven select reads high.
   assign scl_w = scl_h & ~(scl_oe & ~scl_o);
   assign sda_w = sda_h & ~(sda_oe & ~sda_o);
   assign module_select_n = sel_en ? 1'b0 : 1'b1;
   // The two clocks are unrelated in phase.
   initial begin
      core_clk = 1'b0;
      forever #25 core_clk = ~core_clk;
   end
   initial begin
      link_clk = 1'b0;
      #3.7;
      forever #6 link_clk = ~link_clk;
   end
   mmsl_top #(.STRETCH_MAX(STRETCH), .BLINK_CYC(BLINK)) u_dut (
      .core_clk(core_clk), .reset(reset), .link_clk(link_clk),
      .module_select_n(module_select_n), .scl_i(scl_w), .scl_o(scl_o),
      .scl_oe(scl_oe), .sda_i(sda_w), .sda_o(sda_o), .sda_oe(sda_oe),
      .power_high(power_high), .temp_alarm(temp_alarm),
      .led_green(led_green), .led_red(led_red), .mgmt_busy(mgmt_busy));
   mmsl_host_model u_host (
      .link_clk(link_clk), .scl_w(scl_w), .sda_w(sda_w), .scl_h(scl_h),
      .sda_h(sda_h), .rd_cnt(rd_cnt), .rd_data(rd_data));
   // Compares single bits.
   task automatic chk_bit(input string nm, input logic e, input logic g);
      n_tests++;
      if (g !== e) begin
         n_fail++;
         $display("BAD %s expected %b seen %b", nm, e, g);
      end
   endtask
   // Compares bytes.
   task automatic chk_byte(input string nm, input mmsl_byte_t e, g);
      n_tests++;
      if (g !== e) begin
         n_fail++;
         $display("BAD %s expected %h seen %h", nm, e, g);
      end
   endtask
   // Prints the counts and the verdict, then ends the run.
   task automatic end_of_test();
      $display("Compared %0d, mismatched %0d", n_tests, n_fail);
      if (n_fail == 0 && n_tests > 0) begin
         $display("STATUS OK");
      end else begin
         $display("STATUS NOT OK");
      end
      $finish;
   endtask
   // Each byte read by the host is matched to the oldest note.
   always @(rd_cnt) begin
      #1; // Lets the byte settle on its port before it is compared.
      chk_bit("note queue", 1'b1, exp_q.size() > 0);
      chk_byte("read byte", exp_q.pop_front(), rd_data);
   end
   // Measures stretches and watches the data line while deselected.
   always @(posedge link_clk) begin
      run <= scl_oe === 1'b1 ? run + 1 : 0;
      if (run > max_run) max_run <= run;
      if (sda_oe === 1'b1 && module_select_n) oe_rises <= oe_rises + 1;
   end
   // Setup of 40000 cycles plus about 1300 of traffic fits the ceiling.
   always @(posedge core_clk) begin
      cyc <= cyc + 1;
      if (cyc == 45000) begin
         n_fail++;
         end_of_test();
      end
   end
   // Sends one byte and checks the module's answer.
   task automatic send(input mmsl_byte_t b, input logic e);
      u_host.wr_byte(b, ack);
      chk_bit("ack", e, ack);
   endtask
   // Opens a write and sets the byte address.
   task automatic point(input mmsl_byte_t a);
      u_host.start();
      send(8'hA0, 1'b1);
      send(a, 1'b1);
   endtask
   // Reads two bytes from an address.
   task automatic read2(input mmsl_byte_t a);
      point(a);
      u_host.start();
      send(8'hA1, 1'b1);
      u_host.rd_byte(1'b0);
      u_host.rd_byte(1'b1);
      u_host.stop();
   endtask
   // Main sequence.
   initial begin
      seed = 85149;
      {n_fail, n_tests, cyc, run, max_run, oe_rises} = '0;
      reset = 1'b1;
      sel_en = 1'b0;
      power_high = 1'b0;
      temp_alarm = 1'b0;
      repeat (10) @(posedge core_clk);
      reset <= 1'b0;
      for (int i = 0; i < 8; i++) begin
         r = $random(seed);
         @(posedge core_clk);
         power_high <= r[0];
         @(posedge core_clk);
         #1;
         chk_bit("green", r[0], led_green);
         chk_bit("red", ~r[0], led_red);
      end
      @(posedge core_clk);
      temp_alarm <= 1'b1;
      repeat (3) @(posedge core_clk);
      #1;
      flips = 0;
      last = led_green;
      for (int i = 0; i < 4 * BLINK; i++) begin
         @(posedge core_clk);
         #1;
         chk_bit("red opposite", ~led_green, led_red);
         flips += int'(led_green !== last);
         last = led_green;
      end
      chk_bit("blink rate", 1'b1, flips == 4);
      @(posedge core_clk);
      temp_alarm <= 1'b0;
      $display("Indicator test done");
      sel_en <= 1'b1;
      #2000000;
      r = $random(seed);
      d0 = r[7:0];
      d1 = r[15:8];
      point(8'h7F);
      chk_bit("busy", 1'b1, mgmt_busy);
      send(d0, 1'b1);
      send(d1, 1'b1);
      u_host.stop();
      exp_q.push_back(d0);
      exp_q.push_back(d1);
      read2(8'h7F);
      point(8'hFF);
      send(d1, 1'b1);
      u_host.stop();
      exp_q.push_back(d1);
      exp_q.push_back(8'h0D);
      read2(8'hFF);
      chk_bit("notes left", 1'b1, exp_q.size() == 0);
      chk_bit("stretch", 1'b1, max_run > 0 && max_run < STRETCH);
      $display("Write and read test done");
      u_host.start();
      send((r[22:16] == 7'h50) ? 8'hA2 : {r[22:16], 1'b0}, 1'b0);
      chk_bit("busy", 1'b0, mgmt_busy);
      u_host.stop();
      $display("Foreign address test done");
      #10000;
      @(posedge core_clk);
      sel_en <= 1'b0;
      repeat (4) @(posedge core_clk);
      u_host.start();
      send(8'hA0, 1'b0);
      chk_bit("busy", 1'b0, mgmt_busy);
      u_host.stop();
      chk_bit("data line idle", 1'b1, oe_rises == 0);
      $display("Deselect test done");
      end_of_test();
   end
endmodule
